/* File: hdl/tsb_top.sv */
// Transmit FIFO port, transmit sequence control and frame byte counter
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "tsb_defs.svh"
module tsb_top #(
  parameter int FIFO_DEPTH = `TSB_FIFO_DEPTH,
  parameter int FIFO_AW = 3
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic resetn, // Async reset, active low
  input wire logic [`TSB_ADDR_W-1:0] reg_addr, // Register index
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output tsb_pkg::tsb_byte_t reg_rdata, // Read data, cycle after strobe
  input wire logic card_mode, // High in card-slot mode, low in ISA
  input wire logic aux_irq_route6, // Plug-and-play routes an irq to aux pin 6
  input wire logic aux_irq_route5, // Plug-and-play routes an irq to aux pin 5
  input wire logic rx_clock_pin_in, // Level seen on rx clock pin
  input wire logic aux_pin6_in, // Level seen on aux pin 6
  input wire logic aux_pin5_in, // Level seen on aux pin 5
  input wire logic link_lock_pin_in, // Level seen on link-lock pin
  output logic rx_clock_pin_out, // Rx clock pin drive value
  output logic rx_clock_pin_oe_n, // Low while driving rx clock pin
  output logic aux_pin6_out, // Aux pin 6 drive value
  output logic aux_pin6_oe_n, // Low while driving aux pin 6
  output logic aux_pin5_out, // Aux pin 5 drive value
  output logic aux_pin5_oe_n, // Low while driving aux pin 5
  output logic link_lock_pin_out, // Link-lock pin drive value
  output logic link_lock_pin_oe_n, // Low while driving link-lock pin
  output logic tx_cmd_pin, // Transmit command pin
  output logic tx_cmd_n_pin, // Complementary transmit command pin
  output logic tx_mod_pin, // Modulation pin
  output logic tx_pe_pin, // Transmit power-enable pin
  input wire logic fr_tx_start, // Pulse: transmit frame begins
  input wire logic fr_rx_start, // Pulse: receive frame begins
  input wire logic fr_tx_byte, // Pulse: one byte sent after delimiter
  input wire logic fr_tx_crc, // High while CRC bytes go out
  input wire logic fr_rx_byte, // Pulse: one byte written to receive FIFO
  input wire logic phy_pop, // Network side takes one byte
  output tsb_pkg::tsb_byte_t phy_data, // Byte taken, cycle after pop
  output logic tx_fifo_empty // Transmit FIFO empty
);
  import tsb_pkg::*;
  // One clock, one reset; the later checks lean on these
  default clocking main_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [3:0] seq;
    logic [3:0] pin_wr;
    logic [6:0] pincfg;
    tsb_count_t cnt;
    tsb_mode_t mode;
    logic rd_fifo;
    tsb_byte_t rd_hold;
    logic [10:0] pins;
  } tsb_st_t;
  tsb_st_t st_ff, nxt_st;

  logic fifo_push, fifo_pop, fifo_full, fifo_empty;
  logic [FIFO_AW:0] fifo_level;
  tsb_byte_t fifo_q;
  logic wr_fifo, rd_fifo_now;
  logic rc, en6, en5, enl;

  ////////////////////////////////////////////////////////////////////////
  // Transmit FIFO; software and network side share one pop port
  assign wr_fifo = reg_wr && (reg_addr == `TSB_OFF_FIFO);
  assign rd_fifo_now = reg_rd && (reg_addr == `TSB_OFF_FIFO);
  assign fifo_push = wr_fifo;
  assign fifo_pop = rd_fifo_now || (phy_pop && !rd_fifo_now);

  tsb_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .push(fifo_push),
    .push_data(reg_wdata),
    .pop(fifo_pop),
    .pop_data(fifo_q),
    .level(fifo_level),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_fifo = rd_fifo_now;
    nxt_st.rd_hold = '0;
    // Register writes; byte counter writes are dropped to keep it coherent
    if (reg_wr && reg_addr == `TSB_OFF_SEQ) begin
      nxt_st.pin_wr = reg_wdata[7:4];
      nxt_st.seq = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == `TSB_OFF_PINCFG) nxt_st.pincfg = reg_wdata[6:0];
    // Frame counter; a frame start wins over a byte in the same cycle
    if (fr_tx_start) begin
      nxt_st.cnt = '0;
      nxt_st.mode = TSB_TX;
    end else if (fr_rx_start) begin
      nxt_st.cnt = '0;
      nxt_st.mode = TSB_RX;
    end else begin
      unique case (st_ff.mode)
        TSB_IDLE: nxt_st.cnt = st_ff.cnt;
        TSB_TX: if (fr_tx_byte && !fr_tx_crc) nxt_st.cnt = st_ff.cnt + 12'h001;
        TSB_RX: if (fr_rx_byte) nxt_st.cnt = st_ff.cnt + 12'h001;
        default: nxt_st.mode = TSB_IDLE;
      endcase
    end
    // Register read mux; live pin levels for the upper control bits
    if (reg_rd) begin
      unique case (reg_addr)
        `TSB_OFF_SEQ: nxt_st.rd_hold =
          {rx_clock_pin_in, aux_pin6_in, aux_pin5_in, link_lock_pin_in, st_ff.seq};
        `TSB_OFF_CNT_LO: nxt_st.rd_hold = st_ff.cnt[7:0];
        `TSB_OFF_CNT_HI: nxt_st.rd_hold = {4'h0, st_ff.cnt[11:8]};
        `TSB_OFF_PINCFG: nxt_st.rd_hold = {1'b0, st_ff.pincfg};
        `TSB_OFF_FIFO_STAT: nxt_st.rd_hold = {2'h0, fifo_full, fifo_empty, 4'(fifo_level)};
        default: nxt_st.rd_hold = '0;
      endcase
    end
    // Pin drive and enables, all registered
    rc = st_ff.pincfg[`TSB_BIT_RXC_OE] && !st_ff.pincfg[`TSB_BIT_RXC_FN];
    en6 = st_ff.pincfg[`TSB_BIT_AUX6_EN] && !st_ff.pincfg[`TSB_BIT_AUX6_FN] && !(aux_irq_route6 && !card_mode);
    en5 = st_ff.pincfg[`TSB_BIT_AUX5_EN] && !st_ff.pincfg[`TSB_BIT_AUX5_FN] && !(aux_irq_route5 && !card_mode);
    enl = st_ff.pincfg[`TSB_BIT_LLOCK_EN] && card_mode;
    nxt_st.pins[0] = st_ff.pin_wr[3];
    nxt_st.pins[1] = !rc;
    nxt_st.pins[2] = st_ff.pin_wr[2];
    nxt_st.pins[3] = !en6;
    nxt_st.pins[4] = st_ff.pin_wr[1];
    nxt_st.pins[5] = !en5;
    nxt_st.pins[6] = st_ff.pin_wr[0];
    nxt_st.pins[7] = !enl;
    // Register timing: command asserted with modulation when enabled, else bit alone
    nxt_st.pins[8] = st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE] ? (st_ff.seq[`TSB_BIT_TX_COMMAND_PIN_CONTROL] && st_ff.seq[`TSB_BIT_TX_MODULATION_PIN_CONTROL])
      : st_ff.seq[`TSB_BIT_TX_COMMAND_PIN_CONTROL];
    nxt_st.pins[9] = st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE] && st_ff.seq[`TSB_BIT_TX_POWER_ENABLE_PIN_CONTROL];
    nxt_st.pins[10] = !nxt_st.pins[8];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '{seq: `TSB_RST_SEQ, pin_wr: 4'h0, pincfg: `TSB_RST_PINCFG, cnt: `TSB_RST_CNT,
        mode: TSB_IDLE, rd_fifo: 1'b0, rd_hold: 8'h00, pins: 11'h4aa};
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; FIFO data come from the memory's read register
  assign reg_rdata = st_ff.rd_fifo ? fifo_q : st_ff.rd_hold;
  assign phy_data = fifo_q;
  assign tx_fifo_empty = fifo_empty;
  assign rx_clock_pin_out = st_ff.pins[0];
  assign rx_clock_pin_oe_n = st_ff.pins[1];
  assign aux_pin6_out = st_ff.pins[2];
  assign aux_pin6_oe_n = st_ff.pins[3];
  assign aux_pin5_out = st_ff.pins[4];
  assign aux_pin5_oe_n = st_ff.pins[5];
  assign link_lock_pin_out = st_ff.pins[6];
  assign link_lock_pin_oe_n = st_ff.pins[7];
  assign tx_cmd_pin = st_ff.pins[8];
  assign tx_cmd_n_pin = st_ff.pins[10];
  assign tx_mod_pin = st_ff.seq[`TSB_BIT_TX_MODULATION_PIN_CONTROL];
  assign tx_pe_pin = st_ff.pins[9];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_PUSH_LEVEL: assert property (@(posedge clock) disable iff (!resetn)
    (fifo_push && !fifo_full && !fifo_pop) |=> (fifo_level == $past(fifo_level) + 1'b1))
    else $error("fifo port write did not add a byte");
  AST_POP_LEVEL: assert property (@(posedge clock) disable iff (!resetn)
    (rd_fifo_now && !fifo_empty && !fifo_push) |=> (fifo_level == $past(fifo_level) - 1'b1))
    else $error("fifo port read did not remove a byte");
  AST_DEPTH: assert property (@(posedge clock) disable iff (!resetn)
    fifo_level <= (FIFO_AW+1)'(FIFO_DEPTH))
    else $error("fifo level above depth");
  AST_RXC_DRIVE: assert property (@(posedge clock) disable iff (!resetn)
    !rx_clock_pin_oe_n |-> $past(st_ff.pincfg[`TSB_BIT_RXC_OE] && !st_ff.pincfg[`TSB_BIT_RXC_FN]))
    else $error("rx clock pin driven while disabled");
  AST_LLOCK_MODE: assert property (@(posedge clock) disable iff (!resetn)
    !link_lock_pin_oe_n |-> $past(card_mode))
    else $error("link-lock pin driven outside card mode");
  AST_READBACK: assert property (@(posedge clock) disable iff (!resetn)
    (reg_rd && reg_addr == `TSB_OFF_SEQ) |=> (reg_rdata[7:4] ==
    $past({rx_clock_pin_in, aux_pin6_in, aux_pin5_in, link_lock_pin_in})))
    else $error("control read did not return pin levels");
  AST_CMD_PAIR: assert property (@(posedge clock) disable iff (!resetn)
    tx_cmd_n_pin == !tx_cmd_pin)
    else $error("command pins not complementary");
  AST_PE_ZERO: assert property (@(posedge clock) disable iff (!resetn)
    !$past(st_ff.seq[`TSB_BIT_TX_POWER_ENABLE_PIN_CONTROL]) |-> !tx_pe_pin)
    else $error("power enable high without its bit");
  AST_CRC_HOLD: assert property (@(posedge clock) disable iff (!resetn)
    (st_ff.mode == TSB_TX && fr_tx_crc && !fr_tx_start && !fr_rx_start) |=> $stable(st_ff.cnt))
    else $error("CRC byte counted");
  AST_RX_COUNT: assert property (@(posedge clock) disable iff (!resetn)
    (st_ff.mode == TSB_RX && fr_rx_byte && !fr_tx_start && !fr_rx_start) |=>
    (st_ff.cnt == $past(st_ff.cnt) + 12'h001))
    else $error("receive byte not counted");
  AST_CLEAR: assert property (@(posedge clock) disable iff (!resetn)
    (fr_tx_start || fr_rx_start) |=> (st_ff.cnt == 12'h000))
    else $error("counter not cleared at frame start");
  AST_LOW_READ: assert property (@(posedge clock) disable iff (!resetn)
    (reg_rd && reg_addr == `TSB_OFF_CNT_LO) |=> (reg_rdata == $past(st_ff.cnt[7:0])))
    else $error("low count read wrong");

  ////////////////////////////////////////////////////////////////////////
  // FIFO port checks; clock and reset come from the defaults above
  // A full FIFO keeps its level when a write arrives
  AST_FULL_DROP: assert property (
    fifo_push && fifo_full && !fifo_pop
    |=> fifo_level == $past(fifo_level))
    else $error("write into full fifo changed level");
  // A network-side take removes one byte when software is quiet
  AST_PHY_POP: assert property (
    phy_pop && !rd_fifo_now && !fifo_empty && !fifo_push
    |=> fifo_level == $past(fifo_level) - 1'b1)
    else $error("network take did not remove a byte");

  ////////////////////////////////////////////////////////////////////////
  // Pin checks; a pin flop follows its stored bits by one cycle
  // Rx clock pin shows the stored bit while driven
  AST_RXC_VALUE: assert property (
    !rx_clock_pin_oe_n
    |-> rx_clock_pin_out == $past(st_ff.pin_wr[3]))
    else $error("rx clock pin value wrong");
  // Aux pin 6 only driven when enabled as a plain output
  AST_AUX6_DRIVE: assert property (
    !aux_pin6_oe_n
    |-> $past(st_ff.pincfg[`TSB_BIT_AUX6_EN] && !st_ff.pincfg[`TSB_BIT_AUX6_FN]))
    else $error("aux pin 6 driven while disabled");
  // Aux pin 6 shows the stored bit while driven
  AST_AUX6_VALUE: assert property (
    !aux_pin6_oe_n
    |-> aux_pin6_out == $past(st_ff.pin_wr[2]))
    else $error("aux pin 6 value wrong");
  // An interrupt routed in ISA mode owns aux pin 6
  AST_AUX6_IRQ: assert property (
    $past(aux_irq_route6 && !card_mode)
    |-> aux_pin6_oe_n)
    else $error("aux pin 6 driven over routed irq");
  // Aux pin 5 only driven when enabled as a plain output
  AST_AUX5_DRIVE: assert property (
    !aux_pin5_oe_n
    |-> $past(st_ff.pincfg[`TSB_BIT_AUX5_EN] && !st_ff.pincfg[`TSB_BIT_AUX5_FN]))
    else $error("aux pin 5 driven while disabled");
  // Aux pin 5 shows the stored bit while driven
  AST_AUX5_VALUE: assert property (
    !aux_pin5_oe_n
    |-> aux_pin5_out == $past(st_ff.pin_wr[1]))
    else $error("aux pin 5 value wrong");
  // An interrupt routed in ISA mode owns aux pin 5
  AST_AUX5_IRQ: assert property (
    $past(aux_irq_route5 && !card_mode)
    |-> aux_pin5_oe_n)
    else $error("aux pin 5 driven over routed irq");
  // Link-lock pin shows the stored bit while driven
  AST_LLOCK_VALUE: assert property (
    !link_lock_pin_oe_n
    |-> link_lock_pin_out == $past(st_ff.pin_wr[0]))
    else $error("link-lock pin value wrong");

  ////////////////////////////////////////////////////////////////////////
  // Transmit control checks; pins other than modulation lag the stored bits by one cycle
  // Control writes store the low four bits at once
  AST_SEQ_STORE: assert property (
    reg_wr && reg_addr == `TSB_OFF_SEQ
    |=> st_ff.seq == $past(reg_wdata[3:0]))
    else $error("control bits not stored");
  // Modulation pin follows its bit straight from the write
  AST_MOD_PIN: assert property (
    reg_wr && reg_addr == `TSB_OFF_SEQ
    |=> tx_mod_pin == $past(reg_wdata[`TSB_BIT_TX_MODULATION_PIN_CONTROL]))
    else $error("modulation pin wrong");
  // Register timing with modulation low holds the command off
  AST_CMD_HELD: assert property (
    $past(st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE] && !st_ff.seq[`TSB_BIT_TX_MODULATION_PIN_CONTROL])
    |-> !tx_cmd_pin)
    else $error("command pin raised without modulation");
  // Register timing with modulation high passes the command bit
  AST_CMD_WITH_MOD: assert property (
    $past(st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE] && st_ff.seq[`TSB_BIT_TX_MODULATION_PIN_CONTROL])
    |-> tx_cmd_pin == $past(st_ff.seq[`TSB_BIT_TX_COMMAND_PIN_CONTROL]))
    else $error("command pin ignores its bit");
  // Without register timing the command pin is the bit itself
  AST_CMD_DIRECT: assert property (
    $past(!st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE])
    |-> tx_cmd_pin == $past(st_ff.seq[`TSB_BIT_TX_COMMAND_PIN_CONTROL]))
    else $error("command pin differs from its bit");
  // Power enable rises with both its bit and register timing
  AST_PE_SET: assert property (
    $past(st_ff.seq[`TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE] && st_ff.seq[`TSB_BIT_TX_POWER_ENABLE_PIN_CONTROL])
    |-> tx_pe_pin)
    else $error("power enable low with its bit set");

  ////////////////////////////////////////////////////////////////////////
  // Byte counter checks
  // A transmit byte outside the CRC adds one
  AST_TX_COUNT: assert property (
    st_ff.mode == TSB_TX && fr_tx_byte && !fr_tx_crc && !fr_tx_start && !fr_rx_start
    |=> st_ff.cnt == $past(st_ff.cnt) + 12'h001)
    else $error("transmit byte not counted");
  // Frame starts pick the counting direction
  AST_TX_MODE: assert property (
    fr_tx_start
    |=> st_ff.mode == TSB_TX)
    else $error("transmit start did not select transmit");
  AST_RX_MODE: assert property (
    fr_rx_start && !fr_tx_start
    |=> st_ff.mode == TSB_RX)
    else $error("receive start did not select receive");
  // High count read returns the top four bits, upper half zero
  AST_HIGH_READ: assert property (
    reg_rd && reg_addr == `TSB_OFF_CNT_HI
    |=> reg_rdata == {4'h0, $past(st_ff.cnt[11:8])})
    else $error("high count read wrong");

  COV_FULL: cover property (@(posedge clock) disable iff (!resetn) fifo_full);
  COV_TX_FRAME: cover property (@(posedge clock) disable iff (!resetn) fr_tx_start ##[1:20] fr_tx_byte);
  COV_RX_FRAME: cover property (@(posedge clock) disable iff (!resetn) fr_rx_start ##[1:20] fr_rx_byte);
  COV_DIAG_READ: cover property (@(posedge clock) disable iff (!resetn) rd_fifo_now && !fifo_empty);
  COV_CRC_TAIL: cover property (@(posedge clock) disable iff (!resetn) st_ff.mode == TSB_TX && fr_tx_crc);
endmodule

/* File: hdl/tsb_defs.svh */
// Register offsets, field positions, reset values and sizes of the transmit sequence block
`ifndef TSB_DEFS_SVH
`define TSB_DEFS_SVH
`define TSB_ADDR_W 4
`define TSB_OFF_FIFO 4'h0
`define TSB_OFF_SEQ 4'h1
`define TSB_OFF_CNT_LO 4'h2
`define TSB_OFF_CNT_HI 4'h3
`define TSB_OFF_PINCFG 4'h4
`define TSB_OFF_FIFO_STAT 4'h5
`define TSB_BIT_RXC 7
`define TSB_BIT_AUX6 6
`define TSB_BIT_AUX5 5
`define TSB_BIT_LLOCK 4
`define TSB_BIT_REGISTER_TIMING_CONTROL_ENABLE 3
`define TSB_BIT_TX_MODULATION_PIN_CONTROL 2
`define TSB_BIT_TX_POWER_ENABLE_PIN_CONTROL 1
`define TSB_BIT_TX_COMMAND_PIN_CONTROL 0
`define TSB_BIT_RXC_OE 0
`define TSB_BIT_RXC_FN 1
`define TSB_BIT_AUX6_EN 2
`define TSB_BIT_AUX6_FN 3
`define TSB_BIT_AUX5_EN 4
`define TSB_BIT_AUX5_FN 5
`define TSB_BIT_LLOCK_EN 6
`define TSB_RST_SEQ 4'h0
`define TSB_RST_PINCFG 7'h00
`define TSB_RST_CNT 12'h000
`define TSB_FIFO_DEPTH 8
`endif

/* File: hdl/tsb_pkg.sv */
// Types shared by the transmit sequence block
package tsb_pkg;
  typedef logic [7:0] tsb_byte_t;
  typedef logic [11:0] tsb_count_t;
  typedef enum logic [1:0] {
    TSB_IDLE = 2'b00,
    TSB_TX = 2'b01,
    TSB_RX = 2'b10
  } tsb_mode_t;
endpackage

/* File: hdl/tsb_mem.sv */
// Small byte memory with registered read data
`timescale 1ns/1ps
module tsb_mem #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clock, // System clock
  input wire logic wr_en, // Write strobe
  input wire logic [AW-1:0] wr_addr, // Write entry
  input wire logic [7:0] wr_data, // Write byte
  input wire logic [AW-1:0] rd_addr, // Read entry
  output logic [7:0] rd_data // Registered read byte
);
  logic [7:0] mem [DEPTH];
  // No reset on the array; contents are only valid once written
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: hdl/tsb_fifo.sv */
// Eight-entry byte FIFO with two pointers and a count
`timescale 1ns/1ps
module tsb_fifo #(
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic push, // Write one byte
  input wire logic [7:0] push_data, // Byte to write
  input wire logic pop, // Remove one byte
  output logic [7:0] pop_data, // Byte from the pop, cycle after
  output logic [AW:0] level, // Bytes held
  output logic full, // No space
  output logic empty // Nothing held
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } tsb_fifo_st_t;
  tsb_fifo_st_t st_ff, nxt_st;
  logic do_push, do_pop;

  // Push into a full FIFO or pop from an empty one is dropped
  always_comb begin
    do_push = push && (st_ff.cnt != (AW+1)'(DEPTH));
    do_pop = pop && (st_ff.cnt != '0);
    nxt_st = st_ff;
    if (do_push) nxt_st.wp = st_ff.wp + 1'b1;
    if (do_pop) nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  tsb_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
    .clock(clock),
    .wr_en(do_push),
    .wr_addr(st_ff.wp),
    .wr_data(push_data),
    .rd_addr(st_ff.rp),
    .rd_data(pop_data)
  );

  assign level = st_ff.cnt;
  assign full = (st_ff.cnt == (AW+1)'(DEPTH));
  assign empty = (st_ff.cnt == '0);
endmodule

/* File: bench/tsb_phy_model.sv */
// Behavioural radio-side partner: frame pulses and transmit FIFO pops
`timescale 1ns/1ps
module tsb_phy_model (
  input wire logic clock, // System clock
  input wire logic tx_go, // Start a transmit frame
  input wire logic rx_go, // Start a receive frame
  input wire logic pop_go, // Take one FIFO byte
  input wire logic [11:0] nbytes, // Payload bytes of a frame
  output logic fr_tx_start, // Transmit frame begins
  output logic fr_rx_start, // Receive frame begins
  output logic fr_tx_byte, // Byte sent after delimiter
  output logic fr_tx_crc, // CRC bytes going out
  output logic fr_rx_byte, // Byte into receive FIFO
  output logic phy_pop, // Take one byte
  input wire logic [7:0] phy_data, // Byte taken
  output logic [7:0] got_byte, // Last byte taken
  output logic busy // Job in progress
);
  int i;
  logic rx;
  // One job at a time; bytes two cycles apart, like a slow serialiser
  initial begin
    {fr_tx_start, fr_rx_start, fr_tx_byte, fr_tx_crc, fr_rx_byte, phy_pop, busy} = 7'h00;
    got_byte = 8'h00;
    forever begin
      @(posedge clock);
      if (tx_go || rx_go) begin
        rx = rx_go;
        busy <= 1'b1;
        fr_tx_start <= !rx;
        fr_rx_start <= rx;
        @(posedge clock);
        fr_tx_start <= 1'b0;
        fr_rx_start <= 1'b0;
        // Transmit frames append two CRC bytes that must stay uncounted
        for (i = 0; i < nbytes + (rx ? 0 : 2); i++) begin
          fr_tx_crc <= !rx && (i >= nbytes);
          fr_tx_byte <= !rx;
          fr_rx_byte <= rx;
          @(posedge clock);
          fr_tx_byte <= 1'b0;
          fr_rx_byte <= 1'b0;
          @(posedge clock);
        end
        fr_tx_crc <= 1'b0;
        busy <= 1'b0;
      end else if (pop_go) begin
        // Byte stands in the cycle after the take; busy covers both cycles
        busy <= 1'b1;
        phy_pop <= 1'b1;
        @(posedge clock);
        phy_pop <= 1'b0;
        @(posedge clock);
        got_byte <= phy_data;
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the transmit sequence block
`timescale 1ns/1ps
`include "tsb_defs.svh"
module tb;
  import tsb_pkg::*;
  logic clock, resetn, reg_wr, reg_rd, card_mode, route6, route5, c;
  logic [3:0] reg_addr, oe, outs, pins, p;
  logic [7:0] reg_wdata, d;
  tsb_byte_t reg_rdata, phy_data, got_byte;
  logic rxc_out, rxc_oe_n, a6_out, a6_oe_n, a5_out, a5_oe_n, ll_out, ll_oe_n;
  logic cmd, cmd_n, mod, pe, empty, tx_start, rx_start, tx_byte, tx_crc, rx_byte, pop;
  logic tx_go, rx_go, pop_go, busy;
  logic [11:0] nbytes;
  int bad_count, compares, v;
  logic [6:0] cfg_tab [4] = '{7'h55, 7'h55, 7'h7f, 7'h55};
  logic [2:0] mode_tab [4] = '{3'h7, 3'h3, 3'h4, 3'h0};
  logic [3:0] oe_tab [4] = '{4'h0, 4'h7, 4'he, 4'h1};
  // Released pins float high on their pull-ups
  assign oe = {rxc_oe_n, a6_oe_n, a5_oe_n, ll_oe_n};
  assign outs = {rxc_out, a6_out, a5_out, ll_out};
  assign pins = outs | oe;

  tsb_top uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_mode(card_mode),
    .aux_irq_route6(route6), .aux_irq_route5(route5), .rx_clock_pin_in(pins[3]),
    .aux_pin6_in(pins[2]), .aux_pin5_in(pins[1]), .link_lock_pin_in(pins[0]),
    .rx_clock_pin_out(rxc_out), .rx_clock_pin_oe_n(rxc_oe_n), .aux_pin6_out(a6_out),
    .aux_pin6_oe_n(a6_oe_n), .aux_pin5_out(a5_out), .aux_pin5_oe_n(a5_oe_n),
    .link_lock_pin_out(ll_out), .link_lock_pin_oe_n(ll_oe_n), .tx_cmd_pin(cmd),
    .tx_cmd_n_pin(cmd_n), .tx_mod_pin(mod), .tx_pe_pin(pe), .fr_tx_start(tx_start),
    .fr_rx_start(rx_start), .fr_tx_byte(tx_byte), .fr_tx_crc(tx_crc), .fr_rx_byte(rx_byte),
    .phy_pop(pop), .phy_data(phy_data), .tx_fifo_empty(empty));

  tsb_phy_model phy (.clock(clock), .tx_go(tx_go), .rx_go(rx_go), .pop_go(pop_go),
    .nbytes(nbytes), .fr_tx_start(tx_start), .fr_rx_start(rx_start), .fr_tx_byte(tx_byte),
    .fr_tx_crc(tx_crc), .fr_rx_byte(rx_byte), .phy_pop(pop), .phy_data(phy_data),
    .got_byte(got_byte), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register bus: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask

  // Pin flops follow a control write by two cycles
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Hand one job to the radio model and wait, bounded, for it to finish
  task automatic run(input logic t, input logic r, input logic q);
    int k;
    @(posedge clock);
    tx_go <= t;
    rx_go <= r;
    pop_go <= q;
    @(posedge clock);
    {tx_go, rx_go, pop_go} <= 3'h0;
    for (k = 0; k < 2000; k++) begin
      @(posedge clock);
      #1;
      if (!busy) break;
    end
    if (k == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic frame(input logic r, input logic [11:0] n, input logic [7:0] lo, input logic [3:0] hi);
    nbytes = n;
    run(!r, r, 1'b0);
    rd(`TSB_OFF_CNT_LO, d);
    chk(d, lo);
    rd(`TSB_OFF_CNT_HI, d);
    chk({4'h0, d[3:0]}, {4'h0, hi});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd, card_mode, route6, route5, tx_go, rx_go, pop_go} = 9'h000;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    nbytes = 12'h000;
    bad_count = 0;
    compares = 0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    // Out of reset: no pin driven, control clear, count zero
    chk({4'h0, oe}, 8'h0f);
    rd(`TSB_OFF_SEQ, d);
    chk(d, 8'hf0);
    rd(`TSB_OFF_CNT_LO, d);
    chk(d, 8'h00);
    // Every combination of the four stored transmit bits
    for (v = 0; v < 16; v++) begin
      wr(`TSB_OFF_SEQ, {4'h0, v[3:0]});
      settle();
      c = v[3] ? (v[0] & v[2]) : v[0];
      chk({4'h0, cmd, cmd_n, mod, pe}, {4'h0, c, !c, v[2], v[3] & v[1]});
      rd(`TSB_OFF_SEQ, d);
      chk(d, {4'hf, v[3:0]});
    end
    // Multi-function pins with all enables set, across function selects, mode and routing
    for (v = 0; v < 8; v++) begin
      @(posedge clock);
      {card_mode, route6, route5} <= mode_tab[v/2];
      wr(`TSB_OFF_PINCFG, {1'b0, cfg_tab[v/2]});
      p = v[0] ? 4'ha : 4'h5;
      wr(`TSB_OFF_SEQ, {p, 4'h0});
      settle();
      chk({4'h0, oe}, {4'h0, oe_tab[v/2]});
      chk({4'h0, outs & ~oe_tab[v/2]}, {4'h0, p & ~oe_tab[v/2]});
      rd(`TSB_OFF_SEQ, d);
      chk(d, {p | oe_tab[v/2], 4'h0});
    end
    // Fill past capacity; the ninth byte must be dropped
    for (v = 0; v < 9; v++) begin
      wr(`TSB_OFF_FIFO, 8'h30 + v[7:0]);
    end
    rd(`TSB_OFF_FIFO_STAT, d);
    chk(d, 8'h28);
    rd(`TSB_OFF_FIFO, d);
    chk(d, 8'h30);
    for (v = 1; v < 8; v++) begin
      run(1'b0, 1'b0, 1'b1);
      chk(got_byte, 8'h30 + v[7:0]);
    end
    rd(`TSB_OFF_FIFO_STAT, d);
    chk(d, 8'h10);
    chk({7'h00, empty}, 8'h01);
    // Byte counter over frames; software only reads it
    frame(1'b0, 12'h005, 8'h05, 4'h0);
    frame(1'b1, 12'h003, 8'h03, 4'h0);
    frame(1'b1, 12'h12c, 8'h2c, 4'h1);
    frame(1'b0, 12'h000, 8'h00, 4'h0);
    tally_and_finish();
  end
endmodule
